// File: src/ctxoc_top.sv
`timescale 1ns/1ps
module ctxoc_top (
	input  wire logic                     CORE_CLK_IN,           // core clock
	input  wire logic                     RST_N_IN,              // async, low
	input  wire logic                     LINK_CLK_IN,           // tx clock
	input  wire logic                     POWER_DOWN_BAR_PIN_IN, // pin
	input  wire logic [3:0]               RX_LOCK_IN,            // locks
	input  wire ctxoc_pkg::ctxoc_reg_req_t REG_REQ_IN,           // reg req
	output logic [7:0]                    REG_RDATA_OUT,         // read data
	input  wire ctxoc_pkg::ctxoc_stream_t TX0_STREAM_IN,         // port 0
	input  wire ctxoc_pkg::ctxoc_stream_t TX1_STREAM_IN,         // port 1
	output ctxoc_pkg::ctxoc_lanes_t       TX0_LANES_OUT,         // port 0
	output ctxoc_pkg::ctxoc_lanes_t       TX1_LANES_OUT          // port 1
);
	localparam int unsigned RX_N   = ctxoc_pkg::RX_N;
	localparam int unsigned TX_N   = ctxoc_pkg::TX_N;
	localparam int unsigned XFER_W = ctxoc_pkg::XFER_W;

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	logic [RX_N-1:0] lock_s1_ff;
	logic [RX_N-1:0] lock_s2_ff;
	logic            pwr_s1_ff;
	logic            pwr_s2_ff;

	// pin and lock levels into core clock
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			lock_s1_ff <= '0;
			lock_s2_ff <= '0;
			pwr_s1_ff  <= 1'b0;
			pwr_s2_ff  <= 1'b0;
		end else begin
			lock_s1_ff <= RX_LOCK_IN;
			lock_s2_ff <= lock_s1_ff;
			pwr_s1_ff  <= POWER_DOWN_BAR_PIN_IN;
			pwr_s2_ff  <= pwr_s1_ff;
		end
	end

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	logic [7:0]        gen_cfg_ff;
	logic [7:0]        fwd_one_ff;
	logic [7:0]        fwd_two_ff;
	logic [7:0]        tx_ctl_ff;
	logic [7:0]        rdata_ff;
	logic [7:0]        nxt_gen_cfg;
	logic [7:0]        nxt_fwd_one;
	logic [7:0]        nxt_fwd_two;
	logic [7:0]        nxt_tx_ctl;
	logic [7:0]        nxt_rdata;
	logic [TX_N*2-1:0] st_ff;

	// write decode and read mux
	always_comb begin
		nxt_gen_cfg = gen_cfg_ff;
		nxt_fwd_one = fwd_one_ff;
		nxt_fwd_two = fwd_two_ff;
		nxt_tx_ctl  = tx_ctl_ff;
		if (REG_REQ_IN.wr) begin
			case (REG_REQ_IN.addr)
				ctxoc_pkg::GEN_CFG_ADDR: nxt_gen_cfg = REG_REQ_IN.wdata;
				ctxoc_pkg::FWD_ONE_ADDR: nxt_fwd_one = REG_REQ_IN.wdata;
				ctxoc_pkg::FWD_TWO_ADDR: nxt_fwd_two = REG_REQ_IN.wdata;
				ctxoc_pkg::TX_CTL_ADDR:  nxt_tx_ctl  = REG_REQ_IN.wdata;
				default: nxt_tx_ctl = tx_ctl_ff;
			endcase
		end
		case (REG_REQ_IN.addr)
			ctxoc_pkg::GEN_CFG_ADDR:  nxt_rdata = gen_cfg_ff;
			ctxoc_pkg::GEN_STAT_ADDR: nxt_rdata = {lock_s2_ff, st_ff};
			ctxoc_pkg::FWD_ONE_ADDR:  nxt_rdata = fwd_one_ff;
			ctxoc_pkg::FWD_TWO_ADDR:  nxt_rdata = fwd_two_ff;
			ctxoc_pkg::TX_CTL_ADDR:   nxt_rdata = tx_ctl_ff;
			default:                  nxt_rdata = ctxoc_pkg::RD_NONE;
		endcase
	end

	// register storage
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			gen_cfg_ff <= ctxoc_pkg::GEN_CFG_RST;
			fwd_one_ff <= ctxoc_pkg::FWD_ONE_RST;
			fwd_two_ff <= ctxoc_pkg::FWD_TWO_RST;
			tx_ctl_ff  <= ctxoc_pkg::TX_CTL_RST;
			rdata_ff   <= ctxoc_pkg::RD_NONE;
		end else begin
			gen_cfg_ff <= nxt_gen_cfg;
			fwd_one_ff <= nxt_fwd_one;
			fwd_two_ff <= nxt_fwd_two;
			tx_ctl_ff  <= nxt_tx_ctl;
			rdata_ff   <= nxt_rdata;
		end
	end

	assign REG_RDATA_OUT = rdata_ff;

	// -------------------------------------------------------------
	// pin state selection
	// -------------------------------------------------------------
	logic              repl;
	logic              sleep_sel;
	logic              drv_en;
	logic [RX_N-1:0]   fwd_on;
	logic [RX_N-1:0]   to_one;
	logic [TX_N*2-1:0] nxt_st;

	assign repl   = fwd_two_ff[ctxoc_pkg::REPL_BIT];
	assign sleep_sel = gen_cfg_ff[ctxoc_pkg::SLEEP_BIT];
	assign drv_en    = gen_cfg_ff[ctxoc_pkg::DRV_EN_BIT];
	assign fwd_on = ~fwd_one_ff[ctxoc_pkg::FWD_DIS_LSB +: RX_N];
	assign to_one = fwd_one_ff[ctxoc_pkg::MAP_LSB +: RX_N];

	// per transmit port lock and state
	for (genvar p = 0; p < TX_N; p++) begin : g_port
		logic                  sel_one;
		logic [RX_N-1:0]       mask;
		logic                  lock;
		ctxoc_pkg::ctxoc_pin_t pst;

		// replica follows port 0 lock
		assign sel_one = (p != 0) && !repl;
		assign mask    = fwd_on & (sel_one ? to_one : ~to_one);
		assign lock    = |(lock_s2_ff & mask);

		always_comb begin
			if (!pwr_s2_ff) begin
				pst = ctxoc_pkg::CTXOC_HIZ;
			end else if (!sleep_sel) begin
				pst = ctxoc_pkg::CTXOC_HS0;
			end else if (!drv_en) begin
				pst = ctxoc_pkg::CTXOC_HIZ;
			end else if (lock) begin
				pst = ctxoc_pkg::CTXOC_VALID;
			end else begin
				pst = ctxoc_pkg::CTXOC_HIZ;
			end
		end
		assign nxt_st[p*2 +: 2] = pst;
	end

	// state recomputed each core cycle
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// -------------------------------------------------------------
	// core to link handshake
	// -------------------------------------------------------------
	logic [XFER_W-1:0] xword_ff;
	logic [XFER_W-1:0] nxt_xword;
	logic              req_ff;
	logic              nxt_req;
	logic              ack_ff;
	logic              ack_s1_ff;
	logic              ack_s2_ff;

	// load a new word once the last one is acknowledged
	always_comb begin
		nxt_xword = xword_ff;
		nxt_req   = req_ff;
		if (req_ff == ack_s2_ff) begin
			nxt_xword = {repl, st_ff};
			nxt_req   = ~req_ff;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			xword_ff  <= '0;
			req_ff    <= 1'b0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end else begin
			xword_ff  <= nxt_xword;
			req_ff    <= nxt_req;
			ack_s1_ff <= ack_ff;
			ack_s2_ff <= ack_s1_ff;
		end
	end

	// -------------------------------------------------------------
	// link domain
	// -------------------------------------------------------------
	logic                     lrst_s1_ff;
	logic                     lrst_n_ff;
	logic                     req_s1_ff;
	logic                     req_s2_ff;
	logic [XFER_W-1:0]        lword_ff;
	logic [XFER_W-1:0]        nxt_lword;
	logic                     nxt_ack;
	ctxoc_pkg::ctxoc_stream_t one_stream;

	// reset release aligned to link clock
	always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			lrst_s1_ff <= 1'b0;
			lrst_n_ff  <= 1'b0;
		end else begin
			lrst_s1_ff <= 1'b1;
			lrst_n_ff  <= lrst_s1_ff;
		end
	end

	// capture word when request toggles
	always_comb begin
		nxt_lword = lword_ff;
		nxt_ack   = ack_ff;
		if (req_s2_ff != ack_ff) begin
			nxt_lword = xword_ff;
			nxt_ack   = req_s2_ff;
		end
	end

	always_ff @(posedge LINK_CLK_IN or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			ack_ff    <= 1'b0;
			lword_ff  <= '0;
		end else begin
			req_s1_ff <= req_ff;
			req_s2_ff <= req_s1_ff;
			ack_ff    <= nxt_ack;
			lword_ff  <= nxt_lword;
		end
	end

	// port 1 carries port 0 packets when replicating
	assign one_stream = lword_ff[XFER_W-1] ? TX0_STREAM_IN : TX1_STREAM_IN;

	ctxoc_port_out u_port0 (
		.clk_in    (LINK_CLK_IN),
		.rst_n_in  (lrst_n_ff),
		.state_in  (lword_ff[1:0]),
		.stream_in (TX0_STREAM_IN),
		.lanes_out (TX0_LANES_OUT)
	);

	ctxoc_port_out u_port1 (
		.clk_in    (LINK_CLK_IN),
		.rst_n_in  (lrst_n_ff),
		.state_in  (lword_ff[3:2]),
		.stream_in (one_stream),
		.lanes_out (TX1_LANES_OUT)
	);
endmodule : ctxoc_top

// File: inc/ctxoc_pkg.sv
// Overview of operation
// - replicate bit copies port 0 onto port 1
// - power-down high, sleep select 0 forces HS-0
// - sleep select 1, drive enable 0 gives Hi-Z
// - power-down pin low holds pins Hi-Z
// - both bits set: lock gives valid, else Hi-Z
// - link input active only while receiver locked
// - per port lock is OR of forward-enabled mapped receivers
package ctxoc_pkg;
	// -------------------------------------------------------------
	// sizes
	// -------------------------------------------------------------
	localparam int unsigned RX_N   = 4;
	localparam int unsigned TX_N   = 2;
	localparam int unsigned LANE_W = 32;

	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [7:0] GEN_CFG_ADDR  = 8'h02;
	localparam logic [7:0] GEN_STAT_ADDR = 8'h04;
	localparam logic [7:0] FWD_ONE_ADDR  = 8'h20;
	localparam logic [7:0] FWD_TWO_ADDR  = 8'h21;
	localparam logic [7:0] TX_CTL_ADDR   = 8'h33;

	localparam logic [7:0] GEN_CFG_RST = 8'h00;
	localparam logic [7:0] FWD_ONE_RST = 8'hf0;
	localparam logic [7:0] FWD_TWO_RST = 8'h00;
	localparam logic [7:0] TX_CTL_RST  = 8'h00;
	localparam logic [7:0] RD_NONE     = 8'h00;

	// field positions
	localparam int unsigned DRV_EN_BIT  = 0;
	localparam int unsigned SLEEP_BIT   = 1;
	localparam int unsigned REPL_BIT    = 0;
	localparam int unsigned MAP_LSB     = 0;
	localparam int unsigned FWD_DIS_LSB = 4;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		CTXOC_HIZ,
		CTXOC_HS0,
		CTXOC_VALID
	} ctxoc_pin_t;

	typedef struct packed {
		logic              vld;
		logic [LANE_W-1:0] data;
	} ctxoc_stream_t;

	typedef struct packed {
		logic              drive;
		logic              vld;
		logic [LANE_W-1:0] data;
	} ctxoc_lanes_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ctxoc_reg_req_t;

	localparam int unsigned XFER_W = TX_N * 2 + 1;
endpackage : ctxoc_pkg

// File: src/ctxoc_port_out.sv
`timescale 1ns/1ps
module ctxoc_port_out (
	input  wire logic                   clk_in,     // link clock
	input  wire logic                   rst_n_in,   // link reset, low
	input  wire logic [1:0]             state_in,   // selected pin state
	input  wire ctxoc_pkg::ctxoc_stream_t stream_in, // packet stream
	output ctxoc_pkg::ctxoc_lanes_t     lanes_out   // registered pins
);
	ctxoc_pkg::ctxoc_lanes_t lanes_ff;
	ctxoc_pkg::ctxoc_lanes_t nxt_lanes;

	// pin state to lane drive
	always_comb begin
		nxt_lanes = '0;
		case (ctxoc_pkg::ctxoc_pin_t'(state_in))
			ctxoc_pkg::CTXOC_HIZ: begin
				nxt_lanes.drive = 1'b0;
			end
			ctxoc_pkg::CTXOC_HS0: begin
				nxt_lanes.drive = 1'b1; // lanes held at zero
			end
			ctxoc_pkg::CTXOC_VALID: begin
				nxt_lanes.drive = 1'b1;
				nxt_lanes.vld   = stream_in.vld;
				nxt_lanes.data  = stream_in.data;
			end
			default: begin
				nxt_lanes.drive = 1'b0;
			end
		endcase
	end

	// output register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lanes_ff <= '0;
		end else begin
			lanes_ff <= nxt_lanes;
		end
	end

	assign lanes_out = lanes_ff;
endmodule : ctxoc_port_out

// File: test/ctxoc_properties.sv
`timescale 1ns/1ps
// --------------------------------------------
// pin state checker
// --------------------------------------------
module ctxoc_properties (
	input wire logic                      CORE_CLK_IN,           // core
	input wire logic                      RST_N_IN,              // reset
	input wire logic                      LINK_CLK_IN,           // link
	input wire logic                      POWER_DOWN_BAR_PIN_IN, // pin
	input wire logic [3:0]                RX_LOCK_IN,            // locks
	input wire ctxoc_pkg::ctxoc_reg_req_t REG_REQ_IN,            // req
	input wire logic [7:0]                REG_RDATA_OUT,         // rdata
	input wire ctxoc_pkg::ctxoc_stream_t  TX0_STREAM_IN,         // s0
	input wire ctxoc_pkg::ctxoc_stream_t  TX1_STREAM_IN,         // s1
	input wire ctxoc_pkg::ctxoc_lanes_t   TX0_LANES_OUT,         // l0
	input wire ctxoc_pkg::ctxoc_lanes_t   TX1_LANES_OUT          // l1
);
	logic [7:0] cfg_ff, fwd_ff, rep_ff;
	logic [4:0] cnt_ff;
	logic [3:0] st_ff, st;
	logic       l0, l1, ok;
	// shadow of the written controls
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cfg_ff <= 8'h00;
			fwd_ff <= 8'hf0;
			rep_ff <= 8'h00;
		end else if (REG_REQ_IN.wr) begin
			if (REG_REQ_IN.addr == 8'h02) cfg_ff <= REG_REQ_IN.wdata;
			if (REG_REQ_IN.addr == 8'h20) fwd_ff <= REG_REQ_IN.wdata;
			if (REG_REQ_IN.addr == 8'h21) rep_ff <= REG_REQ_IN.wdata;
		end
	end
	// expected state per port, stable count in link cycles
	assign l0 = |(RX_LOCK_IN & ~fwd_ff[7:4] & ~fwd_ff[3:0]);
	assign l1 = rep_ff[0] ? l0 : |(RX_LOCK_IN & ~fwd_ff[7:4] & fwd_ff[3:0]);
	assign st[1:0] = !POWER_DOWN_BAR_PIN_IN ? 2'h0 : !cfg_ff[1] ? 2'h1 :
		(cfg_ff[0] && l0) ? 2'h2 : 2'h0;
	assign st[3:2] = !POWER_DOWN_BAR_PIN_IN ? 2'h0 : !cfg_ff[1] ? 2'h1 :
		(cfg_ff[0] && l1) ? 2'h2 : 2'h0;
	assign ok = (cnt_ff == 5'h1f) && (st == st_ff);
	always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_ff <= 4'h0;
			cnt_ff <= 5'h00;
		end else begin
			st_ff <= st;
			cnt_ff <= (st != st_ff) ? 5'h00 : cnt_ff + {4'h0, cnt_ff != 5'h1f};
		end
	end
	sequence cfg_idle;
		(REG_REQ_IN.addr == 8'h02 && !REG_REQ_IN.wr) [*2];
	endsequence
	chk_pdb_low_hiz: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && !POWER_DOWN_BAR_PIN_IN
		|-> !TX0_LANES_OUT.drive && !TX1_LANES_OUT.drive) else $error("pd");
	chk_sleep_hs0: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && st[1:0] == 2'h1 |-> TX0_LANES_OUT
		== {1'b1, 1'b0, 32'h0}) else $error("hs0");
	chk_oen_low_hiz: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && POWER_DOWN_BAR_PIN_IN &&
		cfg_ff[1:0] == 2'h2 |-> !TX0_LANES_OUT.drive) else $error("oen");
	chk_valid_data: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && st[1:0] == 2'h2 |-> TX0_LANES_OUT.drive
		&& TX0_LANES_OUT.data == $past(TX0_STREAM_IN.data)) else $error("vd");
	chk_unlocked_hiz: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && POWER_DOWN_BAR_PIN_IN && cfg_ff[1:0]
		== 2'h3 && !l0 |-> !TX0_LANES_OUT.drive) else $error("lock");
	chk_port1_state: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok |-> TX1_LANES_OUT.drive ==
		(st[3:2] != 2'h0)) else $error("port1");
	chk_replicate_copy: assert property (@(posedge LINK_CLK_IN)
		disable iff (!RST_N_IN) ok && rep_ff[0] && st[3:2] == 2'h2 |->
		TX1_LANES_OUT.data == $past(TX0_STREAM_IN.data)) else $error("rep");
	chk_cfg_readback: assert property (@(posedge CORE_CLK_IN)
		disable iff (!RST_N_IN) cfg_idle |=> REG_RDATA_OUT == cfg_ff)
		else $error("cfg");
endmodule : ctxoc_properties
bind ctxoc_top ctxoc_properties chk_u (.CORE_CLK_IN(CORE_CLK_IN),
	.RST_N_IN(RST_N_IN), .LINK_CLK_IN(LINK_CLK_IN),
	.POWER_DOWN_BAR_PIN_IN(POWER_DOWN_BAR_PIN_IN), .RX_LOCK_IN(RX_LOCK_IN),
	.REG_REQ_IN(REG_REQ_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.TX0_STREAM_IN(TX0_STREAM_IN), .TX1_STREAM_IN(TX1_STREAM_IN),
	.TX0_LANES_OUT(TX0_LANES_OUT), .TX1_LANES_OUT(TX1_LANES_OUT));

// File: test/ctxoc_rx_model.sv
`timescale 1ns/1ps
// --------------------------------------------
// downstream receiver model
// --------------------------------------------
module ctxoc_rx_model (
	input  wire logic                    link_clk_in, // link clock
	input  wire ctxoc_pkg::ctxoc_lanes_t lanes0_in,   // port 0 pins
	input  wire ctxoc_pkg::ctxoc_lanes_t lanes1_in,   // port 1 pins
	output logic [31:0]                  word0_out,   // last word 0
	output logic [31:0]                  word1_out    // last word 1
);
	// keep only words seen on driven valid lanes
	always_ff @(posedge link_clk_in) begin
		if (lanes0_in.drive && lanes0_in.vld) word0_out <= lanes0_in.data;
		if (lanes1_in.drive && lanes1_in.vld) word1_out <= lanes1_in.data;
	end
endmodule : ctxoc_rx_model

// File: test/ctxoc_top_bench.sv
`timescale 1ns/1ps
// --------------------------------------------
// register driven bench
// --------------------------------------------
module ctxoc_top_bench;
	logic                      clk, lclk, rst_n, pwr;
	logic [3:0]                lock;
	logic [7:0]                rdata;
	logic [31:0]               w0, w1;
	logic [31:0]               k = 32'h0;
	ctxoc_pkg::ctxoc_reg_req_t req;
	ctxoc_pkg::ctxoc_stream_t  s0, s1;
	ctxoc_pkg::ctxoc_lanes_t   l0, l1;
	int                        miscompares, checks_done, cyc;

	ctxoc_top dut_u (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .LINK_CLK_IN(lclk),
		.POWER_DOWN_BAR_PIN_IN(pwr), .RX_LOCK_IN(lock), .REG_REQ_IN(req),
		.REG_RDATA_OUT(rdata), .TX0_STREAM_IN(s0), .TX1_STREAM_IN(s1),
		.TX0_LANES_OUT(l0), .TX1_LANES_OUT(l1));
	ctxoc_rx_model rx_u (.link_clk_in(lclk), .lanes0_in(l0), .lanes1_in(l1),
		.word0_out(w0), .word1_out(w1));

	// clocks, link one free and out of phase
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#2;
		forever #24 lclk = ~lclk;
	end
	// streams: port 1 differs from port 0 in the upper half
	always @(posedge lclk) begin
		k <= k + 32'h1;
		s0 <= {1'b1, k};
		s1 <= {1'b1, k ^ 32'hffff0000};
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic check(input string n, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		req <= '{1'b1, a, d};
		@(posedge clk);
		req <= '{1'b0, a, d};
	endtask : wr
	task automatic rd(input logic [7:0] a, e, input string n);
		@(posedge clk);
		req <= '{1'b0, a, 8'h00};
		repeat (3) @(posedge clk);
		#2; // odd times never meet a link edge
		check(n, {24'h0, rdata}, {24'h0, e});
	endtask : rd
	task automatic stat(input logic [7:0] e, input string n);
		repeat (200) @(posedge clk);
		rd(8'h04, e, n);
		$display("test %s done", n);
		@(posedge clk);
	endtask : stat
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		rst_n = 1'b0;
		pwr = 1'b0;
		lock = 4'h0;
		req = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h20, 8'hf0, "fwd reset");
		rd(8'h10, 8'h00, "unmapped");
		wr(8'h02, 8'h03);
		lock <= 4'hf;
		stat(8'hf0, "power down");
		check("drive", {30'h0, l1.drive, l0.drive}, 32'h0);
		pwr <= 1'b1;
		wr(8'h02, 8'h01);
		stat(8'hf5, "hs0");
		check("hs0 drive", {30'h0, l1.drive, l0.drive}, 32'h3);
		check("hs0 vld", {30'h0, l1.vld, l0.vld}, 32'h0);
		check("hs0 data", l0.data | l1.data, 32'h0);
		wr(8'h02, 8'h02);
		stat(8'hf0, "drive off");
		wr(8'h33, 8'h01);
		rd(8'h33, 8'h01, "tx enable");
		wr(8'h02, 8'h03);
		stat(8'hf0, "unmapped rx");
		wr(8'h20, 8'h02);
		lock <= 4'h0;
		stat(8'h00, "no lock");
		lock <= 4'h4;
		stat(8'h42, "port0 valid");
		check("drive", {30'h0, l1.drive, l0.drive}, 32'h1);
		lock <= 4'h3;
		stat(8'h3a, "both valid");
		check("split", w0 ^ w1, 32'hffff0000);
		wr(8'h20, 8'hf0);
		wr(8'h21, 8'h01);
		wr(8'h20, 8'h00);
		lock <= 4'h1;
		stat(8'h1a, "replicate");
		check("copy", w1, w0);
		wr(8'h20, 8'hf0);
		wr(8'h33, 8'h00);
		stat(8'h10, "shutdown");
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h21, 8'h00, "rep reset");
		test_done();
	end
endmodule : ctxoc_top_bench
